// ===== src/dmcs_channel.sv
// Purpose: One DMA channel: request generation and address sequencing
// Assumes: APB register access, bus cycles run by an outside bus unit
// Notes:   Data path is not modelled, only its holding state
//
// Behaviour
// - Single address: RW high memory to device
// - Dual address: source pointer reads, destination writes
// - Each pointer incs, decs or holds independently
// - Single address: one or two cycles, step one, two or four
// - No memory stepping keeps one address
// - Dual address: two to six cycles per operand
// - Narrow side takes one, two or four cycles
// - Byte on 16-bit port packs two, doubled steps
// - 8-bit port steps device pointer two/four/eight
// - Non-stepping pointer still walks alternate bytes
// - Exception updates nothing, drops held data
// - Restart retries aborted operand from start
// - Counter decrements only after whole operand
// - Internal requests, dual address: no acknowledge
// - Request method chosen; auto-start first internal
// - Maximum rate requests until count exhausted
// - Count grant-acknowledge clocks per sample period
// - Quiet period opens burst window next period
// - Ratio code halves bandwidth per step
// - Burst 16 to 128, period up to 2048
module dmcs_channel
  import dmcs_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        RESET_N,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  input  wire logic        REQ_IN,
  input  wire logic        BUS_GRANT_ACK_IN,
  output logic             CYC_VALID,
  output logic      [23:0] CYC_ADDR,
  output logic      [2:0]  CYC_FC,
  output logic             CYC_RW,
  output logic             CYC_WORD,
  output logic             CYC_ACK,
  input  wire logic        CYC_DONE,
  input  wire logic        CYC_ERR
);
  // ==========================================================
  // Register file
  logic [5:0]  operation_control_reg;
  logic [3:0]  sequence_control_reg;
  logic        device_control_reg;
  logic [3:0]  general_control_reg;
  logic [2:0]  memory_function_code_reg;
  logic [2:0]  device_function_code_reg;
  logic [23:0] memory_address_pointer;
  logic [23:0] device_address_pointer;
  logic [15:0] memory_transfer_counter;
  logic        active_reg;
  logic        done_reg;
  logic        error_reg;
  logic        first_reg;
  logic        hold_reg;
  logic        pack_reg;
  logic [2:0]  part_reg;
  logic [2:0]  cyc_cnt_reg;
  logic [31:0] prdata_reg;
  dmcs_state_t state_reg;

  logic        wr_acc;
  logic        rd_setup;
  logic        start;
  logic        dir_m2d;
  logic        single;
  logic [1:0]  op_size;
  logic [1:0]  req_mode;
  logic        internal;
  logic        allow;
  logic        request;
  logic        pack_ok;
  logic [2:0]  mem_parts;
  logic [2:0]  dev_parts;
  logic [3:0]  mem_step;
  logic [3:0]  dev_step;
  logic        use_mem;
  logic [2:0]  phase_parts;
  logic        last_part;
  logic        op_end;
  logic [15:0] unit;

  // Field views
  assign dir_m2d  = !operation_control_reg[OPER_DIR];
  assign op_size  = operation_control_reg[OPER_SIZE +: 2];
  assign req_mode = operation_control_reg[OPER_REQ +: 2];
  assign single   = operation_control_reg[OPER_SINGLE];
  assign internal = (req_mode == REQ_MAX) || (req_mode == REQ_LIM);

  // ==========================================================
  // APB slave: zero wait states, read data caught in setup
  assign PREADY   = 1'b1;
  assign PRDATA   = prdata_reg;
  assign wr_acc   = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign start    = wr_acc && PADDR == OFS_CTRL && PWDATA[0] && !active_reg;

  // Unmapped or misaligned addresses answer with an error
  always_comb
  begin
    PSLVERR = PSEL && PENABLE && (PADDR[1:0] != 2'b00 || PADDR > OFS_MCNT);
  end

  // Read mux
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
      prdata_reg <= RST_ZERO;
    else if (rd_setup)
    begin
      case (PADDR)
        OFS_STAT: prdata_reg <= {29'h0, error_reg, done_reg, active_reg};
        OFS_OPER: prdata_reg <= {26'h0, operation_control_reg};
        OFS_SEQ:  prdata_reg <= {28'h0, sequence_control_reg};
        OFS_DEV:  prdata_reg <= {31'h0, device_control_reg};
        OFS_GEN:  prdata_reg <= {28'h0, general_control_reg};
        OFS_MPTR: prdata_reg <= {8'h00, memory_address_pointer};
        OFS_DPTR: prdata_reg <= {8'h00, device_address_pointer};
        OFS_MFC:  prdata_reg <= {29'h0, memory_function_code_reg};
        OFS_DFC:  prdata_reg <= {29'h0, device_function_code_reg};
        OFS_MCNT: prdata_reg <= {16'h0000, memory_transfer_counter};
        default:  prdata_reg <= RST_ZERO;
      endcase
    end
  end

  // Setup registers; locked while the channel runs, rate always open
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      operation_control_reg    <= 6'h00;
      sequence_control_reg     <= 4'h0;
      device_control_reg       <= 1'b0;
      general_control_reg      <= 4'h0;
      memory_function_code_reg <= 3'h0;
      device_function_code_reg <= 3'h0;
    end
    else if (wr_acc)
    begin
      if (PADDR == OFS_GEN)
        general_control_reg <= PWDATA[3:0];
      if (!active_reg)
      begin
        case (PADDR)
          OFS_OPER: operation_control_reg    <= PWDATA[5:0];
          OFS_SEQ:  sequence_control_reg     <= PWDATA[3:0];
          OFS_DEV:  device_control_reg       <= PWDATA[0];
          OFS_MFC:  memory_function_code_reg <= PWDATA[2:0];
          OFS_DFC:  device_function_code_reg <= PWDATA[2:0];
          default:  ;
        endcase
      end
    end
  end

  // ==========================================================
  // Request generation
  dmcs_rate_meter u_rate (
    .clk   (CLOCK),
    .rst_n (RESET_N),
    .grant_ack  (BUS_GRANT_ACK_IN),
    .burst_code (general_control_reg[GEN_BURST +: 2]),
    .ratio_code (general_control_reg[GEN_RATIO +: 2]),
    .allow      (allow)
  );

  // Method select; auto-start makes only its first request itself
  always_comb
  begin
    case (req_mode)
      REQ_EXT:  request = REQ_IN;
      REQ_AUTO: request = first_reg || REQ_IN;
      REQ_MAX:  request = 1'b1;
      REQ_LIM:  request = allow;
      default:  request = 1'b0;
    endcase
  end

  // ==========================================================
  // Operand planning; packing needs even pointers stepping up
  assign pack_ok = !single && device_control_reg && op_size == SZ_BYTE && internal
                   && memory_transfer_counter >= 16'd2 && !memory_address_pointer[0]
                   && !device_address_pointer[0]
                   && sequence_control_reg[SEQ_MEM +: 2] == STEP_INC
                   && sequence_control_reg[SEQ_DEV +: 2] == STEP_INC;

  dmcs_plan u_plan (
    .size      (1'b0),
    .op_size   (op_size),
    .port16    (device_control_reg),
    .single    (single),
    .pair_mode (pack_reg),
    .mem_parts (mem_parts),
    .dev_parts (dev_parts),
    .mem_step  (mem_step),
    .dev_step  (dev_step)
  );

  // Source pointer in read phase, destination in write phase
  assign use_mem     = single || ((state_reg == ST_READ) == dir_m2d);
  assign phase_parts = use_mem ? mem_parts : dev_parts;
  assign last_part   = (part_reg == phase_parts - 3'd1);
  assign op_end      = CYC_VALID && CYC_DONE && last_part
                       && (single || state_reg == ST_WRITE);
  assign unit        = pack_reg ? 16'd2 : 16'd1;

  // ==========================================================
  // Bus cycle outputs
  always_comb
  begin
    CYC_VALID = (state_reg == ST_READ) || (state_reg == ST_WRITE);
    // Parts always sit two bytes apart, even for a still pointer
    CYC_ADDR  = (use_mem ? memory_address_pointer : device_address_pointer)
                + {20'h00000, part_reg, 1'b0};
    CYC_FC    = use_mem ? memory_function_code_reg : device_function_code_reg;
    if (single)
      CYC_RW = dir_m2d;
    else
      CYC_RW = (state_reg == ST_READ);
    CYC_WORD  = pack_reg || (op_size != SZ_BYTE && (use_mem || device_control_reg));
    // Device gets acknowledge on every single address cycle, in dual only on its own side under external or auto-start requests
    CYC_ACK   = CYC_VALID && (single || (!use_mem && !internal));
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      state_reg <= ST_IDLE;
      part_reg  <= 3'd0;
      pack_reg  <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
          if (start)
            state_reg <= ST_WAIT;
        ST_WAIT:
          if (request)
          begin
            // Every operand starts at part zero, also after a retry
            state_reg <= ST_READ;
            part_reg  <= 3'd0;
            pack_reg  <= pack_ok;
          end
        ST_READ, ST_WRITE:
          if (CYC_ERR)
            state_reg <= ST_IDLE;
          else if (CYC_DONE && !last_part)
            part_reg <= part_reg + 3'd1;
          else if (CYC_DONE && (single || state_reg == ST_WRITE))
            state_reg <= (memory_transfer_counter == unit) ? ST_IDLE : ST_WAIT;
          else if (CYC_DONE)
          begin
            state_reg <= ST_WRITE;
            part_reg  <= 3'd0;
          end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // Channel status; auto-start first request spent on first operand
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      active_reg <= 1'b0;
      done_reg   <= 1'b0;
      error_reg  <= 1'b0;
      first_reg  <= 1'b0;
    end
    else if (start)
    begin
      active_reg <= memory_transfer_counter != 16'h0000;
      done_reg   <= 1'b0;
      error_reg  <= 1'b0;
      first_reg  <= 1'b1;
    end
    else
    begin
      if (state_reg == ST_WAIT && request)
        first_reg <= 1'b0;
      if (CYC_VALID && CYC_ERR)
      begin
        active_reg <= 1'b0;
        error_reg  <= 1'b1;
      end
      else if (op_end && memory_transfer_counter == unit)
      begin
        active_reg <= 1'b0;
        done_reg   <= 1'b1;
      end
    end
  end

  // Holding register state: filled after reads, lost on bus error
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || (CYC_VALID && CYC_ERR) || op_end)
      hold_reg <= 1'b0;
    else if (state_reg == ST_READ && CYC_DONE && last_part && !single)
      hold_reg <= 1'b1;
  end

  // Pointers and counter move only on a whole, clean operand
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N)
    begin
      memory_address_pointer  <= 24'h00_0000;
      device_address_pointer  <= 24'h00_0000;
      memory_transfer_counter <= 16'h0000;
    end
    else if (wr_acc && !active_reg)
    begin
      if (PADDR == OFS_MPTR)
        memory_address_pointer <= PWDATA[23:0];
      if (PADDR == OFS_DPTR)
        device_address_pointer <= PWDATA[23:0];
      if (PADDR == OFS_MCNT)
        memory_transfer_counter <= PWDATA[15:0];
    end
    else if (op_end && !CYC_ERR)
    begin
      memory_transfer_counter <= memory_transfer_counter - unit;
      case (sequence_control_reg[SEQ_MEM +: 2])
        STEP_INC: memory_address_pointer <= memory_address_pointer + {20'h00000, mem_step};
        STEP_DEC: memory_address_pointer <= memory_address_pointer - {20'h00000, mem_step};
        default:  ;
      endcase
      if (!single)
      begin
        case (sequence_control_reg[SEQ_DEV +: 2])
          STEP_INC: device_address_pointer <= device_address_pointer + {20'h00000, dev_step};
          STEP_DEC: device_address_pointer <= device_address_pointer - {20'h00000, dev_step};
          default:  ;
        endcase
      end
    end
  end

  // Bus cycles run for the current operand, checked below
  always_ff @(posedge CLOCK)
  begin
    if (!RESET_N || state_reg == ST_WAIT)
      cyc_cnt_reg <= 3'd0;
    else if (CYC_VALID && CYC_DONE && cyc_cnt_reg != 3'd7)
      cyc_cnt_reg <= cyc_cnt_reg + 3'd1;
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESET_N);

  AST_SINGLE_RW: assert property (CYC_VALID && single |-> CYC_RW == dir_m2d)
    else $error("single address direction wrong");
  AST_DUAL_SRC: assert property (state_reg == ST_READ && !single && dir_m2d
                                 |-> CYC_FC == memory_function_code_reg)
    else $error("memory to device read not from memory");
  AST_STILL_PTR: assert property (op_end && sequence_control_reg[1:0] == STEP_NONE
                                  |=> $stable(memory_address_pointer))
    else $error("still memory pointer moved");
  AST_INC_PTR: assert property (op_end && !CYC_ERR && sequence_control_reg[1:0] == STEP_INC
                                |=> memory_address_pointer == $past(memory_address_pointer)
                                    + $past(mem_step))
    else $error("memory pointer step wrong");
  AST_ERR_HOLD: assert property (CYC_VALID && CYC_ERR |=> $stable(memory_address_pointer)
                                 && $stable(memory_transfer_counter) && !hold_reg
                                 && state_reg == ST_IDLE)
    else $error("bus error changed pointers");
  AST_CNT_DEC: assert property (op_end && !CYC_ERR |=> memory_transfer_counter
                                == $past(memory_transfer_counter) - $past(unit))
    else $error("counter not stepped per operand");
  AST_CNT_HOLD: assert property (CYC_DONE && !op_end |=> $stable(memory_transfer_counter))
    else $error("counter moved mid operand");
  AST_NO_ACK: assert property (CYC_VALID && !single && internal |-> !CYC_ACK)
    else $error("acknowledge during internal dual transfer");
  AST_DUAL_CYCLES: assert property (op_end && !single && !pack_reg
                                    |-> cyc_cnt_reg >= 3'd1 && cyc_cnt_reg <= 3'd5)
    else $error("dual operand cycle count out of range");
  AST_MAX_RATE: assert property (state_reg == ST_WAIT && req_mode == REQ_MAX
                                 |=> state_reg == ST_READ)
    else $error("maximum rate did not request at once");
  AST_RESTART: assert property (state_reg == ST_WAIT && request |=> part_reg == 3'd0)
    else $error("operand not started from its first part");

  COV_PACKED: cover property (op_end && pack_reg);
  COV_ERROR: cover property (CYC_VALID && CYC_ERR && hold_reg);
  COV_DONE: cover property (op_end && memory_transfer_counter == unit);
endmodule : dmcs_channel

// ===== src/dmcs_pkg.sv
// Purpose: Shared constants for the channel sequencing and request block
// Assumes: 32-bit APB, word aligned registers
// Notes:   Field positions live here only; register reset values are literals in the channel
package dmcs_pkg;
  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL  = 8'h00;
  localparam logic [7:0] OFS_STAT  = 8'h04;
  localparam logic [7:0] OFS_OPER  = 8'h08;
  localparam logic [7:0] OFS_SEQ   = 8'h0C;
  localparam logic [7:0] OFS_DEV   = 8'h10;
  localparam logic [7:0] OFS_GEN   = 8'h14;
  localparam logic [7:0] OFS_MPTR  = 8'h18;
  localparam logic [7:0] OFS_DPTR  = 8'h1C;
  localparam logic [7:0] OFS_MFC   = 8'h20;
  localparam logic [7:0] OFS_DFC   = 8'h24;
  localparam logic [7:0] OFS_MCNT  = 8'h28;
  // ==========================================================
  // Field positions
  localparam int OPER_DIR    = 0;  // 0 memory to device
  localparam int OPER_SIZE   = 1;  // [2:1]
  localparam int OPER_REQ    = 3;  // [4:3]
  localparam int OPER_SINGLE = 5;
  localparam int SEQ_MEM     = 0;  // [1:0]
  localparam int SEQ_DEV     = 2;  // [3:2]
  localparam int GEN_BURST   = 0;  // [1:0]
  localparam int GEN_RATIO   = 2;  // [3:2]
  // ==========================================================
  // Encodings and reset values
  localparam logic [1:0] SZ_BYTE   = 2'h0;
  localparam logic [1:0] SZ_WORD   = 2'h1;
  localparam logic [1:0] SZ_LONG   = 2'h2;
  localparam logic [1:0] STEP_NONE = 2'h0;
  localparam logic [1:0] STEP_INC  = 2'h1;
  localparam logic [1:0] STEP_DEC  = 2'h2;
  localparam logic [1:0] REQ_EXT   = 2'h0;
  localparam logic [1:0] REQ_AUTO  = 2'h1;
  localparam logic [1:0] REQ_MAX   = 2'h2;
  localparam logic [1:0] REQ_LIM   = 2'h3;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [11:0] BURST_BASE = 12'h010;  // 16 clocks
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_READ  = 2'b10,
    ST_WRITE = 2'b11
  } dmcs_state_t;
endpackage : dmcs_pkg

// ===== src/dmcs_plan.sv
// Purpose: Bus cycle counts and pointer steps per operand
// Assumes: Memory side is 16 bits wide
// Notes:   Pure combinational decode
module dmcs_plan
  import dmcs_pkg::*;
(
  input  wire logic       size,
  input  wire logic [1:0] op_size,
  input  wire logic       port16,
  input  wire logic       single,
  input  wire logic       pair_mode,
  output logic [2:0]      mem_parts,
  output logic [2:0]      dev_parts,
  output logic [3:0]      mem_step,
  output logic [3:0]      dev_step
);
  // ==========================================================
  // Parts and steps by operand and port size
  always_comb
  begin
    mem_parts = (op_size == SZ_LONG) ? 3'd2 : 3'd1;
    mem_step  = (op_size == SZ_LONG) ? 4'd4 : (op_size == SZ_WORD) ? 4'd2 : 4'd1;
    if (port16)
    begin
      dev_parts = mem_parts;
      dev_step  = mem_step;
    end
    else
    begin
      dev_parts = (op_size == SZ_LONG) ? 3'd4 : (op_size == SZ_WORD) ? 3'd2 : 3'd1;
      dev_step  = mem_step << 1;
    end
    if (single)
      dev_parts = 3'd0;
    if (pair_mode)
    begin
      mem_step = mem_step << 1;
      dev_step = dev_step << 1;
    end
    if (size)
      mem_parts = mem_parts;
  end
endmodule : dmcs_plan

// ===== src/dmcs_rate_meter.sv
// Purpose: Limited-rate request window from bus grant activity
// Assumes: One clock, grant acknowledge sampled synchronously
// Notes:   Window opens only if last period was quiet enough
module dmcs_rate_meter
  import dmcs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       grant_ack,
  input  wire logic [1:0] burst_code,
  input  wire logic [1:0] ratio_code,
  output logic            allow
);
  logic [11:0] period_reg;
  logic [11:0] busy_reg;
  logic        ok_reg;
  logic [11:0] burst;
  logic [11:0] period_len;
  logic        boundary;

  // ==========================================================
  // Burst and sample period lengths
  assign burst      = BURST_BASE << burst_code;
  assign period_len = burst << ({1'b0, ratio_code} + 3'd1);
  assign boundary   = (period_reg == period_len - 12'd1);
  assign allow      = ok_reg && (period_reg < burst);

  // Period position, cleared at each boundary
  always_ff @(posedge clk)
  begin
    if (!rst_n || boundary)
      period_reg <= 12'h000;
    else
      period_reg <= period_reg + 12'd1;
  end

  // Busy clocks by any master, ourselves included
  always_ff @(posedge clk)
  begin
    if (!rst_n || boundary)
      busy_reg <= 12'h000;
    else if (grant_ack)
      busy_reg <= busy_reg + 12'd1;
  end

  // Verdict for the next period; a busy last clock counts too
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ok_reg <= 1'b1;
    else if (boundary)
      ok_reg <= (busy_reg + {11'h000, grant_ack}) < burst;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  AST_RATE_WINDOW: assert property (allow |-> period_reg < burst)
    else $error("request window outside burst time");
  AST_RATE_CLEAR: assert property (boundary |=> period_reg == 0 && busy_reg == 0)
    else $error("counters not cleared at period end");
  AST_RATE_BUSY: assert property (boundary && busy_reg >= burst |=> !allow [*8])
    else $error("window opened after busy period");
  COV_RATE_OPEN: cover property (boundary ##1 allow);
endmodule : dmcs_rate_meter

// ===== verif/dmcs_bus_model.sv
// Purpose: Memory and peripheral responder for the channel bus cycles
// Assumes: One done or error pulse answers each requested cycle
// Notes:   Random wait of zero to three clocks per cycle
module dmcs_bus_model
  import dmcs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        cyc_valid,
  input  wire logic [15:0] err_at,
  output logic             cyc_done,
  output logic             cyc_err
);
  timeunit 1ns;
  timeprecision 1ns;
  int          seed     = 4975;
  int          wait_cnt = 0;
  logic [15:0] n        = 16'h0000;
  // ==========================================================
  // Responder
  initial
  begin
    cyc_done = 1'b0;
    cyc_err  = 1'b0;
  end
  // Slow answers show whether the request holds still meanwhile
  always @(posedge clk)
  begin
    cyc_done <= 1'b0;
    cyc_err  <= 1'b0;
    if (cyc_valid && !cyc_done && !cyc_err)
    begin
      if (wait_cnt == 0)
      begin
        cyc_err  <= (n == err_at);  // Only the cycle the bench names fails
        cyc_done <= (n != err_at);
        n        <= n + 16'h0001;
        wait_cnt <= {$random(seed)} % 4;
      end
      else
        wait_cnt <= wait_cnt - 1;
    end
  end
endmodule : dmcs_bus_model

// ===== verif/tb_top.sv
// Purpose: Self-checking bench for one sequencing channel
// Assumes: Zero-wait APB slave, partner answers every cycle
// Notes:   Pointers and rate fields are random, fixed seed
module tb_top
  import dmcs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================
  // Signals
  logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        req = 1'b0, bga = 1'b0, se, prdy, perr, cv, crw, cw, cak, cdn, cer;
  logic [7:0]  pa = '0;
  logic [31:0] pwd = '0, prd, rd;
  logic [23:0] ca, m, d;
  logic [2:0]  cfc;
  logic [15:0] err_at = 16'hFFFF, ncyc = '0;
  logic [29:0] log_q[$];
  int          errors = 0, total_checks = 0, seed = 4975, ticks = 0;
  localparam logic [29:0] ALL = 30'h3FFF_FFFF, NOACK = 30'h1FFF_FFFF;
  dmcs_channel i_dmcs_channel (.CLOCK(clk), .RESET_N(rst_n), .PSEL(psel), .PENABLE(pen),
    .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
    .REQ_IN(req), .BUS_GRANT_ACK_IN(bga), .CYC_VALID(cv), .CYC_ADDR(ca), .CYC_FC(cfc),
    .CYC_RW(crw), .CYC_WORD(cw), .CYC_ACK(cak), .CYC_DONE(cdn), .CYC_ERR(cer));
  dmcs_bus_model i_dmcs_bus_model (.clk(clk), .cyc_valid(cv), .err_at(err_at),
    .cyc_done(cdn), .cyc_err(cer));
  // ==========================================================
  // Clock, bus cycle log and hang guard
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Entry is {ack, rw, word, fc, addr} of each finished cycle
  always @(posedge clk)
  begin
    ticks++;
    if (cv && (cdn || cer))
    begin
      log_q.push_back({cak, crw, cw, cfc, ca});
      ncyc++;
    end
    if (ticks == 30000)
    begin
      errors++;
      close_out();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    pwr  <= w;
    pa   <= a;
    pwd  <= wd;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (prdy !== 1'b1);
    rd = prd;
    se = perr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb
  task automatic reg_is(input logic [7:0] a, input logic [23:0] e);
    apb(1'b0, a, '0);
    chk($sformatf("register %h", a), {8'h00, e}, rd);
  endtask : reg_is
  task automatic sc(input int i, input logic [29:0] e, input logic [29:0] mk);
    chk($sformatf("bus cycle %0d", i), {2'b00, e & mk}, {2'b00, log_q[i] & mk});
  endtask : sc
  // Start, then poll until the active flag drops
  task automatic go();
    log_q = {};
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    do
      apb(1'b0, OFS_STAT, '0);
    while (rd[0] !== 1'b0);
  endtask : go
  // Fresh even pointers, fixed function codes, then a run
  task automatic run(input logic [7:0] op, input logic [3:0] sq, input logic dv, input logic [15:0] c);
    m = 24'($random(seed)) & 24'hFF_FFFE;
    d = 24'($random(seed)) & 24'hFF_FFFE;
    apb(1'b1, OFS_OPER, 32'(op));
    apb(1'b1, OFS_SEQ, 32'(sq));
    apb(1'b1, OFS_DEV, 32'(dv));
    apb(1'b1, OFS_MPTR, 32'(m));
    apb(1'b1, OFS_DPTR, 32'(d));
    apb(1'b1, OFS_MFC, 32'h0000_0005);
    apb(1'b1, OFS_DFC, 32'h0000_0002);
    apb(1'b1, OFS_MCNT, 32'(c));
    go();
  endtask : run
  function automatic logic [23:0] nxt(input logic [23:0] p, input logic [1:0] md, input int n);
    return md == STEP_INC ? p + 24'(n) : md == STEP_DEC ? p - 24'(n) : p;
  endfunction : nxt
  task automatic close_out();
    $display("Checks %0d, errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  // ==========================================================
  // Scenarios
  initial
  begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    // Reset values, with holes and half-word offsets refused
    for (int a = 0; a < 48; a += 2)
    begin
      apb(1'b0, a[7:0], '0);
      chk("slave error", 32'(a > 40 || a % 4 != 0), 32'(se));
      if (a % 4 == 0 && a <= 40)
        chk("reset value", '0, rd);
    end
    // Single address: bytes stepping up, then words at one address
    run(8'h30, 4'h1, 1'b0, 16'h0003);
    chk("count", 3, log_q.size());
    for (int k = 0; k < 3; k++)
      sc(k, {3'b010, 3'h5, m + 24'(k)}, NOACK);
    reg_is(OFS_MCNT, '0);
    run(8'h33, 4'h0, 1'b1, 16'h0002);
    for (int k = 0; k < 2; k++)
      sc(k, {3'b001, 3'h5, m}, NOACK);
    // Dual words, external then maximum-rate requests
    for (int r = 0; r < 2; r++)
    begin
      req <= (r == 0);
      run(r ? 8'h12 : 8'h02, 4'h9, 1'b1, 16'h0002);
      for (int k = 0; k < 2; k++)
      begin
        sc(2 * k, {3'b011, 3'h5, nxt(m, STEP_INC, 2 * k)}, ALL);
        sc(2 * k + 1, {r == 0, 2'b01, 3'h2, nxt(d, STEP_DEC, 2 * k)}, ALL);
      end
      reg_is(OFS_DPTR, nxt(d, STEP_DEC, 4));
    end
    // Auto-start: first operand needs no request, the next waits for the pin
    apb(1'b1, OFS_OPER, 32'h0000_000A);
    apb(1'b1, OFS_MCNT, 32'h0000_0002);
    log_q = {};
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (40) @(posedge clk);
    chk("count", 2, log_q.size());
    req <= 1'b1;
    go();
    chk("count", 2, log_q.size());
    // Long operands from an 8-bit port, device pointer held then stepped
    for (int s = 0; s < 2; s++)
    begin
      run(8'h15, 4'h1 | 4'(s << 2), 1'b0, 16'h0001);
      chk("count", 6, log_q.size());
      for (int k = 0; k < 4; k++)
        sc(k, {3'b010, 3'h2, d + 24'(2 * k)}, ALL);
      for (int k = 0; k < 2; k++)
        sc(k + 4, {3'b001, 3'h5, m + 24'(2 * k)}, ALL);
      reg_is(OFS_DPTR, nxt(d, s[1:0], 8));
    end
    // Write cycle fails: nothing moves, restart retries the operand
    err_at <= ncyc + 16'h0001;
    run(8'h12, 4'h5, 1'b1, 16'h0002);
    reg_is(OFS_STAT, 24'h00_0004);
    reg_is(OFS_MPTR, m);
    reg_is(OFS_MCNT, 24'h00_0002);
    go();
    sc(0, {3'b011, 3'h5, m}, ALL);
    chk("count", 4, log_q.size());
    // Byte pairs on a 16-bit port travel as words, steps doubled
    run(8'h10, 4'h5, 1'b1, 16'h0002);
    sc(0, {3'b011, 3'h5, m}, ALL);
    sc(1, {3'b001, 3'h2, d}, ALL);
    reg_is(OFS_MPTR, m + 24'h00_0002);
    // A busy bus blocks limited-rate requests until it goes quiet
    bga <= 1'b1;
    apb(1'b1, OFS_GEN, 32'({$random(seed)} % 16));
    repeat (2100) @(posedge clk);
    apb(1'b1, OFS_OPER, 32'h0000_001A);
    apb(1'b1, OFS_MCNT, 32'h0000_0001);
    log_q = {};
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    repeat (100) @(posedge clk);
    chk("count", 0, log_q.size());
    bga <= 1'b0;
    do
      apb(1'b0, OFS_STAT, '0);
    while (rd[0] !== 1'b0);
    chk("count", 2, log_q.size());
    close_out();
  end
endmodule : tb_top
